// ==== tb_async_rx_clock_data_recovery.sv ====
// Self-checking bench of the receive recovery block.
// Assumes the transmitter model drives the serial line on tick edges.

`timescale 1ns/1ps
`default_nettype none

module tb_async_rx_clock_data_recovery;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic sample_tick_in = 1'b0;
  logic double_speed_select_in = 1'b0;
  logic [3:0] char_bits_in = 4'h8;
  logic [1:0] tick_div = 2'h0;
  logic serial_line;
  logic frame_valid_out;
  logic start_valid_out;
  logic busy_out;
  urx_pkg::urx_frame_s frame_out;
  urx_pkg::urx_frame_s exp_q[$];
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 30729;
  int n_start_exp = 0;
  int n_start_seen = 0;

  always #5 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    tick_div <= tick_div + 2'h1;
    sample_tick_in <= (tick_div == 2'h3);
  end

  urx_recovery dut (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sample_tick_in(sample_tick_in),
    .serial_rx_input_in(serial_line),
    .double_speed_select_in(double_speed_select_in),
    .char_bits_in(char_bits_in),
    .frame_valid_out(frame_valid_out),
    .frame_out(frame_out),
    .start_valid_out(start_valid_out),
    .busy_out(busy_out)
  );

  urx_tx_model tx (
    .clk_in(clk_in),
    .tick_in(sample_tick_in),
    .line_out(serial_line)
  );

  // ****************************************************************
  // Checking
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge clk_in) begin
    if (start_valid_out === 1'b1) n_start_seen++;
    if (frame_valid_out === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0, "extra frame");
      else check(frame_out, exp_q.pop_front(), "frame");
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic frame(input int len, input logic stop, input int bt,
      input int st, input int gap, input bit gl);
    logic [9:0] d;
    int l;
    urx_pkg::urx_frame_s e;
    d = 10'($random(seed));
    l = (len < 5) ? 5 : (len > 10) ? 10 : len;
    char_bits_in <= 4'(len);
    e.data = d & ((10'h001 << l) - 10'h001);
    e.bits = 4'(l);
    e.frame_error_flag = ~stop;
    exp_q.push_back(e);
    n_start_exp++;
    tx.send(d, l, stop, bt, st, gap, gl);
  endtask : frame

  initial begin : main
    int ds;
    int len;
    int spb;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(negedge clk_in);
    check({busy_out, start_valid_out, frame_valid_out, frame_out}, 0,
        "reset");
    tx.hold(2);
    for (ds = 0; ds < 2; ds++) begin
      double_speed_select_in <= ds[0];
      spb = ds ? 8 : 16;
      tx.hold(2);
      // Low through the first voting sample still loses the vote.
      tx.spike(spb / 2, 3 * spb);
      @(negedge clk_in);
      check(busy_out, 0, "spike");
      tx.hold(1);
      for (len = 5; len <= 10; len++) begin
        frame(len, 1'b1, spb, spb, 2, len[0]);
      end
      frame(8, 1'b0, spb, spb, 3, 1'b0);
      frame(6, 1'b1, spb, ds ? 6 : 10, 0, 1'b0);
      frame(7, 1'b1, spb, spb, 2, 1'b1);
      $display("mode %0d done", ds);
    end
    double_speed_select_in <= 1'b0;
    tx.hold(2);
    frame(5, 1'b1, 17, 17, 4, 1'b0);
    frame(4, 1'b1, 16, 16, 2, 1'b0);
    frame(11, 1'b1, 16, 16, 2, 1'b1);
    repeat (40) @(negedge clk_in);
    check(exp_q.size(), 0, "frames left");
    check(n_start_seen, n_start_exp, "starts");
    $display("slow and clamp done");
    report_and_stop();
  end

  // The whole run needs about 10k clocks; five times that means a hang.
  initial begin : watchdog
    #500_000;
    n_mismatch++;
    report_and_stop();
  end
endmodule : tb_async_rx_clock_data_recovery

`default_nettype wire

// ==== urx_recovery.sv ====
// Receive-side clock and data recovery of an asynchronous serial port.
// Assumes sample_tick_in pulses once per oversample period (16 or 8 per
// bit) and that the serial input is already synchronous to clk_in.

`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Sample the line at 16x baud, or 8x with double speed selected.
// - A high-to-low sample starts qualification; first low is sample one.
// - Start judged on samples 8,9,10, or 4,5,6 in double speed.
// - Two or more high qualifying samples reject start; watch again.
// - Valid start aligns bit phase and begins recovery, every frame.
// - Sixteen sample states per bit, eight in double speed.
// - Each bit is the majority of its three centre samples.
// - Recover bits through the first stop bit; ignore further stops.
// - First stop bit voted alike; zero sets the frame error flag.
// - Ready for next start right after the stop bit's last vote.
// - Character plus parity length from five to ten bits.
// - First vote sample 8 or 4, middle sample 9 or 5.
// - Frame error travels with its frame's data.
module urx_recovery (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sample_tick_in,
  input wire logic serial_rx_input_in,
  input wire logic double_speed_select_in,
  input wire logic [3:0] char_bits_in,
  output logic frame_valid_out,
  output urx_pkg::urx_frame_s frame_out,
  output logic start_valid_out,
  output logic busy_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  urx_pkg::urx_state_e state;
  urx_pkg::urx_state_e next_state;
  logic [4:0] sample_cnt;
  logic [3:0] bit_idx;
  logic [3:0] frame_len;
  logic [9:0] shift_data;
  logic prev_sample;
  logic frame_valid;
  urx_pkg::urx_frame_s frame;
  logic start_valid;
  logic decide;
  logic vote;

  // ****************************************************************
  // Sample numbering
  // ****************************************************************
  wire [4:0] spb = double_speed_select_in ? urx_pkg::SPB_DS
                                          : urx_pkg::SPB_NORM;
  wire urx_pkg::urx_vote_pos_s pos = double_speed_select_in ?
    {urx_pkg::VOTE_FIRST_DS, urx_pkg::VOTE_MID_DS, urx_pkg::VOTE_LAST_DS} :
    {urx_pkg::VOTE_FIRST_NORM, urx_pkg::VOTE_MID_NORM,
     urx_pkg::VOTE_LAST_NORM};
  wire active = (state != urx_pkg::URX_IDLE);
  wire falling = sample_tick_in && !active && prev_sample &&
                 !serial_rx_input_in;
  wire wrap = (sample_cnt >= spb);
  // Number of the sample being taken on this tick.
  wire [4:0] cur_num = wrap ? urx_pkg::SAMPLE_ONE
                            : 5'(sample_cnt + 5'h01);
  wire sample_en = sample_tick_in && active;
  wire last_data = (bit_idx == 4'(frame_len - 4'h1));
  wire [3:0] len_clamped =
    (char_bits_in < urx_pkg::LEN_MIN) ? urx_pkg::LEN_MIN :
    (char_bits_in > urx_pkg::LEN_MAX) ? urx_pkg::LEN_MAX :
    char_bits_in;

  // ****************************************************************
  // Majority voter
  // ****************************************************************
  urx_vote u_vote (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .sample_en_in(sample_en),
    .sample_num_in(cur_num),
    .sample_in(serial_rx_input_in),
    .pos_in(pos),
    .decide_out(decide),
    .vote_out(vote)
  );

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      urx_pkg::URX_IDLE: begin
        if (falling) begin
          next_state = urx_pkg::URX_START;
        end
      end
      urx_pkg::URX_START: begin
        if (decide) begin
          // A high majority is a noise spike, not a start bit.
          next_state = vote ? urx_pkg::URX_IDLE
                            : urx_pkg::URX_DATA;
        end
      end
      urx_pkg::URX_DATA: begin
        if (decide && last_data) begin
          next_state = urx_pkg::URX_STOP;
        end
      end
      urx_pkg::URX_STOP: begin
        // Leaving at the last vote sample lets an early start be caught
        // on the very next tick; extra stop bits just look like idle.
        if (decide) begin
          next_state = urx_pkg::URX_IDLE;
        end
      end
      default: begin
        next_state = urx_pkg::URX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= urx_pkg::URX_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Sample counter and edge history
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sample_cnt <= urx_pkg::CNT_RESET;
      prev_sample <= 1'b1;
    end else if (sample_tick_in) begin
      prev_sample <= serial_rx_input_in;
      if (falling) begin
        sample_cnt <= urx_pkg::SAMPLE_ONE;
      end else if (active) begin
        sample_cnt <= cur_num;
      end
    end
  end

  // ****************************************************************
  // Data capture
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      bit_idx <= urx_pkg::IDX_RESET;
      frame_len <= urx_pkg::LEN_MIN;
      shift_data <= urx_pkg::DATA_RESET;
    end else if (falling) begin
      // Length is latched per frame so a change mid-frame cannot tear it.
      frame_len <= len_clamped;
      bit_idx <= urx_pkg::IDX_RESET;
      shift_data <= urx_pkg::DATA_RESET;
    end else if (decide && state == urx_pkg::URX_DATA) begin
      shift_data[bit_idx] <= vote;
      bit_idx <= 4'(bit_idx + 4'h1);
    end
  end

  // ****************************************************************
  // Results
  // ****************************************************************
  wire stop_decide = decide && (state == urx_pkg::URX_STOP);
  wire start_ok = decide && (state == urx_pkg::URX_START) && !vote;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      frame_valid <= 1'b0;
      start_valid <= 1'b0;
      frame <= '0;
    end else begin
      frame_valid <= stop_decide;
      start_valid <= start_ok;
      if (stop_decide) begin
        frame.data <= shift_data;
        frame.bits <= frame_len;
        frame.frame_error_flag <= !vote;
      end
    end
  end

  assign frame_valid_out = frame_valid;
  assign frame_out = frame;
  assign start_valid_out = start_valid;
  assign busy_out = active;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_start_edge;
    @(posedge clk_in) disable iff (!reset_n_in)
    (state == urx_pkg::URX_IDLE && sample_tick_in && prev_sample &&
     !serial_rx_input_in)
    |=> (state == urx_pkg::URX_START && sample_cnt == 5'h01);
  endproperty
  a_start_edge: assert property (p_start_edge)
    else $error("Falling edge did not start qualification at sample one.");

  property p_cnt_wrap;
    @(posedge clk_in) disable iff (!reset_n_in)
    (sample_tick_in && active && sample_cnt == spb &&
     $stable(double_speed_select_in))
    |=> (sample_cnt == 5'h01 || state == urx_pkg::URX_IDLE);
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap)
    else $error("Sample counter did not wrap at end of bit period.");

  property p_cnt_bound;
    @(posedge clk_in) disable iff (!reset_n_in)
    sample_cnt <= 5'h10;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound)
    else $error("Sample counter exceeded sixteen states.");

  property p_decide_pos;
    @(posedge clk_in) disable iff (!reset_n_in)
    decide |-> (cur_num == (double_speed_select_in ? 5'h06 : 5'h0a));
  endproperty
  a_decide_pos: assert property (p_decide_pos)
    else $error("Vote decided on the wrong sample number.");

  property p_reject;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_START && vote)
    |=> (state == urx_pkg::URX_IDLE && !start_valid_out);
  endproperty
  a_reject: assert property (p_reject)
    else $error("Noisy start bit was not rejected.");

  property p_accept;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_START && !vote)
    |=> (state == urx_pkg::URX_DATA && bit_idx == 4'h0 && start_valid_out);
  endproperty
  a_accept: assert property (p_accept)
    else $error("Valid start bit did not begin data recovery.");

  property p_bit_store;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_DATA)
    |=> (shift_data[$past(bit_idx)] == $past(vote));
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("Received bit differs from its majority vote.");

  property p_stop_fe;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_STOP)
    |=> (frame_valid_out && frame_out.frame_error_flag == !$past(vote));
  endproperty
  a_stop_fe: assert property (p_stop_fe)
    else $error("Frame error does not match the stop bit vote.");

  property p_ready_next;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_STOP) |=> (state == urx_pkg::URX_IDLE);
  endproperty
  a_ready_next: assert property (p_ready_next)
    else $error("Receiver not idle right after the stop bit vote.");

  // The last data vote must hand over to the stop bit with every bit
  // of the latched length stored, no more and no fewer.
  property p_last_bit;
    @(posedge clk_in) disable iff (!reset_n_in)
    (decide && state == urx_pkg::URX_DATA && last_data)
    |=> (state == urx_pkg::URX_STOP && bit_idx == frame_len);
  endproperty
  a_last_bit: assert property (p_last_bit)
    else $error("Data phase did not end after the latched bit count.");

  property p_frame_len;
    @(posedge clk_in) disable iff (!reset_n_in)
    frame_valid_out |-> (frame_out.bits >= 4'h5 && frame_out.bits <= 4'ha &&
                         $past(state) == urx_pkg::URX_STOP);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("Frame length outside five to ten bits.");

  c_good_frame: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    frame_valid_out && !frame_out.frame_error_flag);
  c_bad_frame: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    frame_valid_out && frame_out.frame_error_flag);
  c_noise: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    decide && state == urx_pkg::URX_START && vote);
  c_ds_frame: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    frame_valid_out && double_speed_select_in);
  c_early_start: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    frame_valid_out ##[1:8] (state == urx_pkg::URX_START));

endmodule : urx_recovery

`default_nettype wire

// ==== urx_tx_model.sv ====
// Behavioural model of the remote asynchronous transmitter.
// Assumes tick_in is the receiver's oversample strobe, one clock wide.

`timescale 1ns/1ps
`default_nettype none

module urx_tx_model (
  input wire logic clk_in,
  input wire logic tick_in,
  output logic line_out
);
  // ****************************************************************
  // Bit timing
  // ****************************************************************
  // Bit lengths are counted in receiver ticks, so a length other than
  // the samples per bit models a transmitter whose rate is off.
  initial line_out = 1'b1;

  task automatic hold(input int n);
    repeat (n) @(posedge clk_in iff tick_in);
  endtask : hold

  // A glitch flips only the middle voting sample of the bit.
  task automatic put(input logic b, input int n, input bit gl);
    line_out <= b;
    if (gl) begin
      hold(n / 2);
      line_out <= ~b;
      hold(1);
      line_out <= b;
      hold(n - n / 2 - 1);
    end else begin
      hold(n);
    end
  endtask : put

  task automatic spike(input int low, input int high);
    line_out <= 1'b0;
    hold(low);
    line_out <= 1'b1;
    hold(high);
  endtask : spike

  // ****************************************************************
  // Frames
  // ****************************************************************
  task automatic send(input logic [9:0] d, input int len, input logic stop,
      input int bt, input int st, input int gap, input bit gl);
    put(1'b0, bt, gl);
    for (int i = 0; i < len; i++) put(d[i], bt, gl);
    put(stop, st, 1'b0);
    if (gap > 0) begin
      line_out <= 1'b1;
      hold(gap);
    end
  endtask : send
endmodule : urx_tx_model

`default_nettype wire

// ==== urx_vote.sv ====
// Shared constants and types of the asynchronous receive recovery block,
// followed by the three-sample majority voter used for every bit.
// Assumes one system clock and a sample strobe from the baud generator.

`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Package
// ****************************************************************
package urx_pkg;
  localparam int CNT_W = 5;
  localparam int LEN_W = 4;
  localparam int DATA_W = 10;
  // Samples per bit period.
  localparam logic [4:0] SPB_NORM = 5'h10;
  localparam logic [4:0] SPB_DS = 5'h08;
  // Sample numbers of the three centre samples.
  localparam logic [4:0] VOTE_FIRST_NORM = 5'h08;
  localparam logic [4:0] VOTE_MID_NORM = 5'h09;
  localparam logic [4:0] VOTE_LAST_NORM = 5'h0a;
  localparam logic [4:0] VOTE_FIRST_DS = 5'h04;
  localparam logic [4:0] VOTE_MID_DS = 5'h05;
  localparam logic [4:0] VOTE_LAST_DS = 5'h06;
  localparam logic [4:0] SAMPLE_ONE = 5'h01;
  localparam logic [4:0] CNT_RESET = 5'h00;
  // Character plus parity length limits.
  localparam logic [3:0] LEN_MIN = 4'h5;
  localparam logic [3:0] LEN_MAX = 4'ha;
  localparam logic [3:0] IDX_RESET = 4'h0;
  localparam logic [9:0] DATA_RESET = 10'h000;

  typedef enum logic [1:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_STOP
  } urx_state_e;

  typedef struct packed {
    logic [9:0] data;
    logic [3:0] bits;
    logic frame_error_flag;
  } urx_frame_s;

  typedef struct packed {
    logic [4:0] first;
    logic [4:0] mid;
    logic [4:0] last;
  } urx_vote_pos_s;
endpackage : urx_pkg

// ****************************************************************
// Majority voter
// ****************************************************************
module urx_vote (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic sample_en_in,
  input wire logic [4:0] sample_num_in,
  input wire logic sample_in,
  input wire urx_pkg::urx_vote_pos_s pos_in,
  output logic decide_out,
  output logic vote_out
);
  logic s_first;
  logic s_mid;
  wire take_first = sample_en_in && (sample_num_in == pos_in.first);
  wire take_mid = sample_en_in && (sample_num_in == pos_in.mid);

  // The third sample is used live so the decision lands on its own tick.
  assign decide_out = sample_en_in && (sample_num_in == pos_in.last);
  assign vote_out = (s_first & s_mid) | (s_first & sample_in) |
                    (s_mid & sample_in);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      s_first <= 1'b1;
      s_mid <= 1'b1;
    end else begin
      if (take_first) begin
        s_first <= sample_in;
      end
      if (take_mid) begin
        s_mid <= sample_in;
      end
    end
  end
endmodule : urx_vote

`default_nettype wire
